// ### src/usm_pkg.sv
// constants and types for the serial port status block
package usm_pkg;

  // register byte addresses, one word each
  localparam logic [4:0] ADDR_DATA   = 5'h00;
  localparam logic [4:0] ADDR_IER    = 5'h04;
  localparam logic [4:0] ADDR_IIR    = 5'h08;
  localparam logic [4:0] ADDR_MCR    = 5'h10;
  localparam logic [4:0] ADDR_LSR    = 5'h14;
  localparam logic [4:0] ADDR_MSR    = 5'h18;

  // reset values
  localparam logic [3:0] IER_RST     = 4'h0;
  localparam logic [4:0] MCR_RST     = 5'h00;
  localparam logic [1:0] TRIG_RST    = 2'h0;

  // modem control bit positions
  localparam int MCR_DTR   = 0;
  localparam int MCR_RTS   = 1;
  localparam int MCR_RI    = 2;
  localparam int MCR_IRQEN = 3;
  localparam int MCR_LOOP  = 4;

  // interrupt enable bit positions
  localparam int IER_RX    = 0;
  localparam int IER_THRE  = 1;
  localparam int IER_LS    = 2;
  localparam int IER_MS    = 3;

  // fifo control bit positions
  localparam int FCR_EN    = 0;
  localparam int FCR_RXRST = 1;
  localparam int FCR_TXRST = 2;
  localparam int FCR_DMA   = 3;
  localparam int FCR_TRIG  = 6;

  // receive trigger levels in bytes
  localparam logic [4:0] TRIG_LVL0 = 5'h01;
  localparam logic [4:0] TRIG_LVL1 = 5'h04;
  localparam logic [4:0] TRIG_LVL2 = 5'h08;
  localparam logic [4:0] TRIG_LVL3 = 5'h0e;

  // idle character times before a receive timeout
  localparam logic [2:0] TMO_CHARS = 3'h4;

  // interrupt identification codes, bits 3:0
  typedef enum logic [3:0] {
    IID_NONE = 4'b0001,
    IID_LS   = 4'b0110,
    IID_RX   = 4'b0100,
    IID_TMO  = 4'b1100,
    IID_THRE = 4'b0010,
    IID_MS   = 4'b0000
  } usm_iid_t;

  // one received character with its error flags
  typedef struct packed {
    logic       brk;
    logic       frm;
    logic       par;
    logic [7:0] data;
  } usm_rx_char_t;

  // modem inputs, active low at the pins
  typedef struct packed {
    logic dcd_n;
    logic ri_n;
    logic dsr_n;
    logic cts_n;
  } usm_modem_in_t;

endpackage : usm_pkg

// ### src/usm_sync.sv
// three-flop input filter: a change counts once stages two and three agree
`timescale 1ns/10ps
module usm_sync
  import usm_pkg::*;
#(
  parameter int WIDTH = 5
) (
  input  wire logic             i_clk_sys,
  input  wire logic             i_reset,
  input  wire logic [WIDTH-1:0] i_async,
  input  wire logic [WIDTH-1:0] i_rst_val,
  output logic      [WIDTH-1:0] o_level
);

  initial begin
    if (WIDTH < 1) $error("usm_sync: WIDTH must be at least 1");
  end

  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;
  logic [WIDTH-1:0] lvl_q;

  always_ff @(posedge i_clk_sys) begin
    s1_q <= i_async;
    s2_q <= s1_q;
    s3_q <= s2_q;
  end

  // stage one feeds stage two only, so metastability never reaches the filter
  for (genvar g = 0; g < WIDTH; g++) begin : g_bit
    always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
        lvl_q[g] <= i_rst_val[g];
      end else if (s2_q[g] == s3_q[g]) begin
        lvl_q[g] <= s3_q[g];
      end
    end
  end

  assign o_level = lvl_q;

endmodule : usm_sync

// ### src/usm_fifo.sv
// synchronous fifo with flush and fill count
`timescale 1ns/10ps
module usm_fifo
  import usm_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic                     i_clk_sys,
  input  wire logic                     i_reset,
  input  wire logic                     i_flush,
  input  wire logic                     i_push,
  input  wire logic [WIDTH-1:0]         i_data,
  input  wire logic                     i_pop,
  output logic      [WIDTH-1:0]         o_data,
  output logic      [$clog2(DEPTH+1)-1:0] o_count
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH+1);

  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) $error("usm_fifo: DEPTH must be a power of two");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [CW-1:0]    cnt_q;
  logic             do_push;
  logic             do_pop;

  assign do_pop  = i_pop && (cnt_q != '0);
  assign do_push = i_push && ((cnt_q != CW'(DEPTH)) || do_pop);

  always_ff @(posedge i_clk_sys) begin
    if (do_push) begin
      mem[wr_q] <= i_data;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset || i_flush) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (do_push) wr_q <= wr_q + AW'(1);
      if (do_pop)  rd_q <= rd_q + AW'(1);
      cnt_q <= cnt_q + CW'(do_push) - CW'(do_pop);
    end
  end

  assign o_data  = mem[rd_q];
  assign o_count = cnt_q;

endmodule : usm_fifo

// ### src/usm_top.sv
// serial port status, modem handshake, fifo control and interrupt identification
// Operation
// - idle flag only when holding stage and shift register both empty
// - holding empty tracks transmit stage, cleared by data write
// - holding empty with its enable requests the next character
// - break flag when input stays low a whole character time
// - framing flag on missing stop bit, parity flag on wrong parity
// - overrun flag when a new character meets a full receive store; fifo mode drops it, otherwise it overwrites the unread one
// - fifo mode: break, framing, parity describe the head character
// - reading line status clears break, framing, parity and overrun
// - data ready while received data waits, cleared once none remains
// - loopback: serial out high, serial in isolated, modem outputs inactive
// - loopback routes modem control bits 3:0 to modem inputs
// - interrupt output only with modem control bit 3 set
// - rts and dtr pins carry inverted modem control bits 1 and 0
// - modem status 7:4 read inverted dcd, ri, dsr, cts or loopback bits
// - dcd, dsr, cts changes since last status read set bits 3,1,0
// - ring pin low to high since last status read sets bit 2
// - fifo control 7:6 pick 1,4,8,14 byte level; irq above it
// - fifo control bit 3 with bit 0 selects dma mode 1
// - fifo control bits 2,1 reset transmit or receive fifo, self clearing
// - fifo control bit 0 enables fifo mode, set before other bits
// - identification bits 7:6 show fifo mode, 5:4 zero, bit 0 no-pending
// - bits 3:0 encode the highest priority pending source
// - interrupt enable bits 3:0 gate modem, line, transmit, receive sources
//
// The Avalon-MM interface to the registers and the address map were decided locally.
`timescale 1ns/10ps
module usm_top
  import usm_pkg::*;
#(
  parameter int FIFO_DEPTH = 16
) (
  input  wire logic          i_clk_sys,
  input  wire logic          i_reset,
  // avalon-mm slave
  input  wire logic [4:0]    i_avs_address,
  input  wire logic          i_avs_read,
  input  wire logic          i_avs_write,
  input  wire logic [31:0]   i_avs_writedata,
  input  wire logic [3:0]    i_avs_byteenable,
  output logic      [31:0]   o_avs_readdata,
  output logic               o_avs_waitrequest,
  // receiver engine
  input  wire logic          i_rx_valid,
  input  wire usm_rx_char_t  i_rx_char,
  output logic               o_rx_serial,
  // transmitter engine
  input  wire logic          i_tx_take,
  input  wire logic          i_tx_shift_empty,
  input  wire logic          i_tx_serial,
  output logic [7:0]         o_tx_data,
  output logic               o_tx_valid,
  // one pulse per character time from the baud logic
  input  wire logic          i_char_tick,
  // pins
  input  wire logic          i_serial_in,
  input  wire usm_modem_in_t i_modem_n,
  output logic               o_serial_out,
  output logic               o_rts_n,
  output logic               o_dtr_n,
  output logic               o_irq,
  output logic               o_dma_mode1
);

  localparam int CW = $clog2(FIFO_DEPTH+1);

  initial begin
    if (FIFO_DEPTH < 16) $error("usm_top: FIFO_DEPTH must hold the 14 byte level");
  end

  // bus slave: one wait cycle, then the request is taken
  logic        ack_q;
  logic        req;
  logic        acc;
  logic        wr_acc;
  logic        rd_acc;
  logic [7:0]  rd_mux;
  logic [31:0] rdata_q;

  assign req               = i_avs_read || i_avs_write;
  assign o_avs_waitrequest = req && !ack_q;
  assign acc               = req && ack_q;
  assign wr_acc            = acc && i_avs_write && i_avs_byteenable[0];
  assign rd_acc            = acc && i_avs_read;

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req && !ack_q;
    end
  end

  // software registers
  logic [3:0]  ier_q;
  logic [4:0]  mcr_q;
  logic        fifo_en_q;
  logic [1:0]  trig_q;
  logic        dma_q;
  logic        loop;
  logic        fcr_wr;
  logic [7:0]  wb;

  assign wb     = i_avs_writedata[7:0];
  assign loop   = mcr_q[MCR_LOOP];
  assign fcr_wr = wr_acc && (i_avs_address == ADDR_IIR);

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      ier_q <= IER_RST;
    end else if (wr_acc && i_avs_address == ADDR_IER) begin
      ier_q <= wb[3:0];
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      mcr_q <= MCR_RST;
    end else if (wr_acc && i_avs_address == ADDR_MCR) begin
      mcr_q <= wb[4:0];
    end
  end

  // level and dma bits land only with fifo mode on
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      fifo_en_q <= 1'b0;
      trig_q    <= TRIG_RST;
      dma_q     <= 1'b0;
    end else if (fcr_wr) begin
      fifo_en_q <= wb[FCR_EN];
      if (wb[FCR_EN]) begin
        trig_q <= wb[FCR_TRIG +: 2];
        dma_q  <= wb[FCR_DMA];
      end else begin
        dma_q  <= 1'b0;
      end
    end
  end

  assign o_dma_mode1 = dma_q;

  // fifo resets are pulses, so the bits self clear
  logic rx_flush;
  logic tx_flush;
  logic mode_chg;

  assign mode_chg = fcr_wr && (wb[FCR_EN] != fifo_en_q);
  assign rx_flush = fcr_wr && (wb[FCR_RXRST] || mode_chg);
  assign tx_flush = fcr_wr && (wb[FCR_TXRST] || mode_chg);

  // pin inputs through the three-flop filter
  logic [4:0]    pin_lvl;
  usm_modem_in_t mdm_n;
  logic          sin_lvl;

  usm_sync #(
    .WIDTH (5)
  ) u_sync (
    .i_clk_sys (i_clk_sys),
    .i_reset   (i_reset),
    .i_async   ({i_modem_n, i_serial_in}),
    .i_rst_val (5'h1f),
    .o_level   (pin_lvl)
  );

  assign mdm_n   = pin_lvl[4:1];
  assign sin_lvl = pin_lvl[0];

  // loopback wiring
  assign o_rx_serial  = loop ? i_tx_serial : sin_lvl;
  assign o_serial_out = loop ? 1'b1 : i_tx_serial;
  assign o_rts_n      = loop ? 1'b1 : !mcr_q[MCR_RTS];
  assign o_dtr_n      = loop ? 1'b1 : !mcr_q[MCR_DTR];

  // modem status levels, active high
  logic [3:0] ms_now;
  logic [3:0] ms_prev_q;
  logic [3:0] ms_delta_q;
  logic       ms_rd;

  always_comb begin
    if (loop) begin
      ms_now = {mcr_q[MCR_IRQEN], mcr_q[MCR_RI], mcr_q[MCR_DTR], mcr_q[MCR_RTS]};
    end else begin
      ms_now = ~{mdm_n.dcd_n, mdm_n.ri_n, mdm_n.dsr_n, mdm_n.cts_n};
    end
  end

  assign ms_rd = rd_acc && (i_avs_address == ADDR_MSR);

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      ms_prev_q <= 4'h0;
    end else begin
      ms_prev_q <= ms_now;
    end
  end

  // a change in the read cycle survives the clear
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      ms_delta_q <= 4'h0;
    end else begin
      ms_delta_q[3] <= (ms_delta_q[3] && !ms_rd) || (ms_now[3] != ms_prev_q[3]);
      ms_delta_q[2] <= (ms_delta_q[2] && !ms_rd) || (!ms_now[2] && ms_prev_q[2]);
      ms_delta_q[1] <= (ms_delta_q[1] && !ms_rd) || (ms_now[1] != ms_prev_q[1]);
      ms_delta_q[0] <= (ms_delta_q[0] && !ms_rd) || (ms_now[0] != ms_prev_q[0]);
    end
  end

  // receive fifo; one holding entry outside fifo mode
  usm_rx_char_t rx_head;
  logic [CW-1:0] rx_cnt;
  logic          rx_pop;
  logic          rx_push;
  logic          rx_ovr;
  logic          rx_full;

  assign rx_pop  = rd_acc && (i_avs_address == ADDR_DATA);
  assign rx_full = fifo_en_q ? (rx_cnt == CW'(FIFO_DEPTH)) : (rx_cnt != '0);
  // outside fifo mode a new character replaces the unread one
  assign rx_ovr  = i_rx_valid && rx_full;
  assign rx_push = i_rx_valid && (!rx_full || !fifo_en_q);

  usm_fifo #(
    .WIDTH ($bits(usm_rx_char_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_rx_fifo (
    .i_clk_sys (i_clk_sys),
    .i_reset   (i_reset),
    .i_flush   (rx_flush),
    .i_push    (rx_push),
    .i_data    (i_rx_char),
    .i_pop     (rx_pop || (rx_ovr && !fifo_en_q)),
    .o_data    (rx_head),
    .o_count   (rx_cnt)
  );

  // head errors latch one cycle after the head changes
  logic       head_new_q;
  logic       ls_rd;
  logic       oe_q;
  logic [2:0] err_q;
  logic       rx_data_ready_flag;

  assign ls_rd = rd_acc && (i_avs_address == ADDR_LSR);
  assign rx_data_ready_flag   = (rx_cnt != '0);

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      head_new_q <= 1'b0;
    end else begin
      head_new_q <= (rx_push && rx_cnt == '0) || (rx_pop && rx_cnt > CW'(1)) ||
                    (rx_ovr && !fifo_en_q);
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      err_q <= 3'h0;
      oe_q  <= 1'b0;
    end else begin
      if (head_new_q && rx_data_ready_flag) begin
        err_q <= (ls_rd ? 3'h0 : err_q) | {rx_head.brk, rx_head.frm, rx_head.par};
      end else if (ls_rd) begin
        err_q <= 3'h0;
      end
      oe_q <= (oe_q && !ls_rd) || rx_ovr;
    end
  end

  // transmit fifo; outside fifo mode one holding entry
  logic [CW-1:0] tx_cnt;
  logic          tx_push;
  logic          tx_empty;
  logic          tx_empty_q;
  logic          tx_room;

  assign tx_room  = fifo_en_q ? (tx_cnt != CW'(FIFO_DEPTH)) : (tx_cnt == '0);
  assign tx_push  = wr_acc && (i_avs_address == ADDR_DATA) && tx_room;
  assign tx_empty = (tx_cnt == '0);
  assign o_tx_valid = !tx_empty;

  usm_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_tx_fifo (
    .i_clk_sys (i_clk_sys),
    .i_reset   (i_reset),
    .i_flush   (tx_flush),
    .i_push    (tx_push),
    .i_data    (wb),
    .i_pop     (i_tx_take),
    .o_data    (o_tx_data),
    .o_count   (tx_cnt)
  );

  // transmit-empty event latch; write or id read clears it
  logic thre_pend_q;
  logic thre_set;
  logic thre_clr;
  logic iir_rd;

  assign iir_rd   = rd_acc && (i_avs_address == ADDR_IIR);
  assign thre_set = (tx_empty && !tx_empty_q) ||
                    (wr_acc && i_avs_address == ADDR_IER && wb[IER_THRE] &&
                     !ier_q[IER_THRE] && tx_empty);
  assign thre_clr = tx_push || (iir_rd && rdata_q[3:0] == IID_THRE);

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      tx_empty_q  <= 1'b1;
      thre_pend_q <= 1'b0;
    end else begin
      tx_empty_q  <= tx_empty;
      thre_pend_q <= thre_set || (thre_pend_q && !thre_clr);
    end
  end

  // receive timeout: character times since the last fifo access
  logic [2:0] tmo_cnt_q;
  logic       tmo;

  always_ff @(posedge i_clk_sys) begin
    if (i_reset || !fifo_en_q || !rx_data_ready_flag || rx_push || rx_pop) begin
      tmo_cnt_q <= 3'h0;
    end else if (i_char_tick && tmo_cnt_q != TMO_CHARS) begin
      tmo_cnt_q <= tmo_cnt_q + 3'h1;
    end
  end

  assign tmo = (tmo_cnt_q == TMO_CHARS);

  // interrupt sources and priority
  logic [4:0] trig_lvl;
  logic       rx_lvl;
  usm_iid_t   iid;

  always_comb begin
    unique case (trig_q)
      2'b00: trig_lvl = TRIG_LVL0;
      2'b01: trig_lvl = TRIG_LVL1;
      2'b10: trig_lvl = TRIG_LVL2;
      2'b11: trig_lvl = TRIG_LVL3;
    endcase
  end

  // the count must pass the level, so the 1 byte level needs two bytes
  assign rx_lvl = fifo_en_q ? (rx_cnt > CW'(trig_lvl)) : rx_data_ready_flag;

  always_comb begin
    if (ier_q[IER_LS] && (oe_q || err_q != 3'h0)) begin
      iid = IID_LS;
    end else if (ier_q[IER_RX] && rx_lvl) begin
      iid = IID_RX;
    end else if (ier_q[IER_RX] && tmo) begin
      iid = IID_TMO;
    end else if (ier_q[IER_THRE] && thre_pend_q) begin
      iid = IID_THRE;
    end else if (ier_q[IER_MS] && ms_delta_q != 4'h0) begin
      iid = IID_MS;
    end else begin
      iid = IID_NONE;
    end
  end

  assign o_irq = mcr_q[MCR_IRQEN] && (iid != IID_NONE);

  // read mux
  logic temt;

  assign temt = tx_empty && i_tx_shift_empty;

  always_comb begin
    unique case (i_avs_address)
      ADDR_DATA: rd_mux = rx_data_ready_flag ? rx_head.data : 8'h00;
      ADDR_IER:  rd_mux = {4'h0, ier_q};
      ADDR_IIR:  rd_mux = {{2{fifo_en_q}}, 2'b00, iid};
      ADDR_MCR:  rd_mux = {3'h0, mcr_q};
      ADDR_LSR:  rd_mux = {1'b0, temt, tx_empty, err_q, oe_q, rx_data_ready_flag};
      ADDR_MSR:  rd_mux = {ms_now, ms_delta_q};
      default:   rd_mux = 8'h00;
    endcase
  end

  // read data are captured in the wait cycle and stand through the accept edge
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      rdata_q <= 32'h0;
    end else if (i_avs_read && !ack_q) begin
      rdata_q <= {24'h0, rd_mux};
    end
  end

  assign o_avs_readdata = rdata_q;

endmodule : usm_top

// ### test/usm_top_asserts.sv
// concurrent checks on the port behaviour of usm_top
`timescale 1ns/10ps
module usm_top_asserts
  import usm_pkg::*;
(
  input  wire logic        i_clk_sys,
  input  wire logic        i_reset,
  input  wire logic [4:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  input  wire logic [31:0] o_avs_readdata,
  input  wire logic        o_avs_waitrequest,
  input  wire logic        i_tx_take,
  input  wire logic        i_tx_serial,
  input  wire logic        o_tx_valid,
  input  wire logic        o_rx_serial,
  input  wire logic        o_serial_out,
  input  wire logic        o_rts_n,
  input  wire logic        o_dtr_n,
  input  wire logic        o_irq,
  input  wire logic        o_dma_mode1
);
  logic [4:0] mcr_q;
  logic       wr_ok;
  logic       rd_ok;
  logic       fcr_wr;
  assign wr_ok = i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0];
  assign rd_ok = i_avs_read && !o_avs_waitrequest;
  assign fcr_wr = wr_ok && i_avs_address == ADDR_IIR;
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      mcr_q <= MCR_RST;
    end else if (wr_ok && i_avs_address == ADDR_MCR) begin
      mcr_q <= i_avs_writedata[4:0];
    end
  end
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);
  property p_irq_gate; o_irq |-> mcr_q[MCR_IRQEN]; endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq without enable bit");
  property p_rts; o_rts_n == (mcr_q[MCR_LOOP] || !mcr_q[MCR_RTS]); endproperty
  a_rts: assert property (p_rts) else $error("rts pin wrong");
  property p_dtr; o_dtr_n == (mcr_q[MCR_LOOP] || !mcr_q[MCR_DTR]); endproperty
  a_dtr: assert property (p_dtr) else $error("dtr pin wrong");
  property p_serial_out; o_serial_out == (mcr_q[MCR_LOOP] || i_tx_serial); endproperty
  a_serial_out: assert property (p_serial_out) else $error("serial out wrong");
  property p_rx_loop; mcr_q[MCR_LOOP] |-> o_rx_serial == i_tx_serial; endproperty
  a_rx_loop: assert property (p_rx_loop) else $error("loopback rx path wrong");
  property p_iir_fields;
    rd_ok && i_avs_address == ADDR_IIR |-> o_avs_readdata[5:4] == 2'b00
      && o_avs_readdata[7] == o_avs_readdata[6];
  endproperty
  a_iir_fields: assert property (p_iir_fields) else $error("ident fields wrong");
  property p_ier_hi; rd_ok && i_avs_address == ADDR_IER |-> o_avs_readdata[7:4] == 4'h0;
  endproperty
  a_ier_hi: assert property (p_ier_hi) else $error("enable high bits set");
  property p_tx_rst; fcr_wr && i_avs_writedata[FCR_TXRST] |=> !o_tx_valid; endproperty
  a_tx_rst: assert property (p_tx_rst) else $error("tx reset left data");
  property p_tx_load;
    wr_ok && i_avs_address == ADDR_DATA && !i_tx_take |-> ##1 o_tx_valid;
  endproperty
  a_tx_load: assert property (p_tx_load) else $error("tx write not held");
  property p_dma;
    fcr_wr |=> o_dma_mode1 == $past(i_avs_writedata[FCR_EN] && i_avs_writedata[FCR_DMA]);
  endproperty
  a_dma: assert property (p_dma) else $error("dma mode wrong");
  cp_irq: cover property (o_irq);
  cp_loop: cover property (mcr_q[MCR_LOOP] && o_serial_out);
  cp_dma: cover property (o_dma_mode1);
endmodule : usm_top_asserts

bind usm_top usm_top_asserts u_chk (
  .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_avs_address(i_avs_address),
  .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
  .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
  .o_avs_waitrequest(o_avs_waitrequest), .i_tx_take(i_tx_take), .i_tx_serial(i_tx_serial),
  .o_tx_valid(o_tx_valid), .o_rx_serial(o_rx_serial), .o_serial_out(o_serial_out),
  .o_rts_n(o_rts_n), .o_dtr_n(o_dtr_n), .o_irq(o_irq), .o_dma_mode1(o_dma_mode1)
);

// ### test/usm_modem_model.sv
// modem model: cts and dsr answer rts and dtr late, ring and carrier on command
`timescale 1ns/10ps
module usm_modem_model
  import usm_pkg::*;
#(
  parameter int LAT = 3
) (
  input  wire logic     i_clk_sys,
  input  wire logic     i_rts_n,
  input  wire logic     i_dtr_n,
  input  wire logic     i_ring,
  input  wire logic     i_carrier,
  output usm_modem_in_t o_modem_n,
  output logic          o_serial_in
);
  logic [LAT-1:0] cts_q = '1;
  logic [LAT-1:0] dsr_q = '1;
  // answers lag, as a real modem's do
  always_ff @(posedge i_clk_sys) begin
    cts_q <= {cts_q[LAT-2:0], i_rts_n};
    dsr_q <= {dsr_q[LAT-2:0], i_dtr_n};
  end
  assign o_modem_n = {~i_carrier, ~i_ring, dsr_q[LAT-1], cts_q[LAT-1]};
  // idle line rests at mark
  assign o_serial_in = 1'b1;
endmodule : usm_modem_model

// ### test/usm_top_tb_top.sv
// self-checking bench for the serial port status, modem, fifo and interrupt block
`timescale 1ns/10ps
module usm_top_tb_top;
  import usm_pkg::*;
  logic          clk = 1'b0, rst = 1'b1, av_r = 1'b0, av_w = 1'b0, wreq;
  logic [4:0]    adr = '0;
  logic [3:0]    be = 4'h1;
  logic [31:0]   wdat = '0, rdat;
  logic          rxv = 1'b0, take = 1'b0, shemp = 1'b1, txs = 1'b1, tick = 1'b0;
  logic          ring = 1'b0, carr = 1'b0, serial_in, rxs, txv, serial_out, rts_n, dtr_n, irq, dma;
  usm_rx_char_t  rxc = '0;
  usm_modem_in_t mdm_n;
  logic [7:0]    txd, d;
  int            errors = 0, num_checks = 0, cyc = 0;
  always #2 clk = ~clk;
  usm_top u_dut (
    .i_clk_sys(clk), .i_reset(rst), .i_avs_address(adr), .i_avs_read(av_r),
    .i_avs_write(av_w), .i_avs_writedata(wdat), .i_avs_byteenable(be),
    .o_avs_readdata(rdat), .o_avs_waitrequest(wreq), .i_rx_valid(rxv), .i_rx_char(rxc),
    .o_rx_serial(rxs), .i_tx_take(take), .i_tx_shift_empty(shemp), .i_tx_serial(txs),
    .o_tx_data(txd), .o_tx_valid(txv), .i_char_tick(tick), .i_serial_in(serial_in),
    .i_modem_n(mdm_n), .o_serial_out(serial_out), .o_rts_n(rts_n), .o_dtr_n(dtr_n),
    .o_irq(irq), .o_dma_mode1(dma)
  );
  usm_modem_model u_mdm (
    .i_clk_sys(clk), .i_rts_n(rts_n), .i_dtr_n(dtr_n), .i_ring(ring), .i_carrier(carr),
    .o_modem_n(mdm_n), .o_serial_in(serial_in)
  );
  task automatic wrap_up;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : wrap_up
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      wrap_up();
    end
  end
  task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic bus(logic w, logic [4:0] a, logic [7:0] v);
    adr <= a;
    wdat <= {24'h0, v};
    av_w <= w;
    av_r <= !w;
    @(posedge clk);
    while (wreq !== 1'b0) @(posedge clk);
    d = rdat[7:0];
    av_w <= 1'b0;
    av_r <= 1'b0;
    @(posedge clk);
  endtask : bus
  task automatic rdc(string nm, logic [4:0] a, logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(nm, d, e);
  endtask : rdc
  task automatic push(usm_rx_char_t c);
    rxc <= c;
    rxv <= 1'b1;
    @(posedge clk);
    rxv <= 1'b0;
    @(posedge clk);
  endtask : push
  task automatic t_reset;
    repeat (8) @(posedge clk);
    chk("pins", {rts_n, dtr_n, irq, dma, serial_out, rxs}, 8'h33);
    rdc("iir", ADDR_IIR, 8'h01);
    rdc("lsr", ADDR_LSR, 8'h60);
    bus(1'b0, ADDR_MSR, 8'h00);
    rdc("msr", ADDR_MSR, 8'h00);
    be <= 4'h0;
    bus(1'b1, ADDR_IER, 8'h0f);
    be <= 4'h1;
    rdc("ier be", ADDR_IER, 8'h00);
    bus(1'b1, ADDR_IER, 8'hf0);
    rdc("ier", ADDR_IER, 8'h00);
    bus(1'b1, 5'h1c, 8'h5a);
    rdc("unmapped", 5'h1c, 8'h00);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_modem;
    bus(1'b1, ADDR_IER, 8'h08);
    bus(1'b1, ADDR_MCR, 8'h0b);
    chk("rts dtr", {rts_n, dtr_n}, 8'h00);
    repeat (10) @(posedge clk);
    chk("irq ms", irq, 8'h01);
    rdc("iir ms", ADDR_IIR, 8'h00);
    rdc("msr up", ADDR_MSR, 8'h33);
    chk("irq ms clr", irq, 8'h00);
    rdc("msr clr", ADDR_MSR, 8'h30);
    ring <= 1'b1;
    repeat (10) @(posedge clk);
    rdc("msr ring", ADDR_MSR, 8'h70);
    ring <= 1'b0;
    repeat (10) @(posedge clk);
    rdc("msr ring end", ADDR_MSR, 8'h34);
    carr <= 1'b1;
    repeat (10) @(posedge clk);
    rdc("msr dcd", ADDR_MSR, 8'hb8);
    carr <= 1'b0;
    bus(1'b1, ADDR_MCR, 8'h00);
    bus(1'b1, ADDR_IER, 8'h00);
    repeat (10) @(posedge clk);
    bus(1'b0, ADDR_MSR, 8'h00);
    $display("t_modem done");
  endtask : t_modem
  task automatic t_loop;
    txs <= 1'b0;
    bus(1'b1, ADDR_MCR, 8'h1f);
    chk("loop pins", {rts_n, dtr_n, serial_out, rxs}, 8'h0e);
    repeat (6) @(posedge clk);
    bus(1'b0, ADDR_MSR, 8'h00);
    chk("msr loop hi", {4'h0, d[7:4]}, 8'h0f);
    bus(1'b1, ADDR_MCR, 8'h15);
    repeat (6) @(posedge clk);
    rdc("msr loop", ADDR_MSR, 8'h69);
    bus(1'b1, ADDR_MCR, 8'h00);
    chk("serial_out", serial_out, 8'h00);
    txs <= 1'b1;
    repeat (10) @(posedge clk);
    bus(1'b0, ADDR_MSR, 8'h00);
    $display("t_loop done");
  endtask : t_loop
  task automatic t_tx;
    bus(1'b1, ADDR_IER, 8'h02);
    chk("irq gated", irq, 8'h00);
    bus(1'b1, ADDR_MCR, 8'h08);
    chk("irq thre", irq, 8'h01);
    rdc("iir thre", ADDR_IIR, 8'h02);
    chk("irq iir clr", irq, 8'h00);
    bus(1'b1, ADDR_DATA, 8'h5a);
    chk("tx out", {txv, txd[6:0]}, 8'hda);
    rdc("lsr full", ADDR_LSR, 8'h00);
    shemp <= 1'b0;
    take <= 1'b1;
    @(posedge clk);
    take <= 1'b0;
    repeat (3) @(posedge clk);
    rdc("lsr shift", ADDR_LSR, 8'h20);
    chk("irq next", irq, 8'h01);
    shemp <= 1'b1;
    repeat (2) @(posedge clk);
    rdc("lsr idle", ADDR_LSR, 8'h60);
    bus(1'b1, ADDR_IER, 8'h00);
    $display("t_tx done");
  endtask : t_tx
  task automatic t_line;
    bus(1'b1, ADDR_IER, 8'h05);
    push('{1'b0, 1'b1, 1'b1, 8'h41});
    repeat (3) @(posedge clk);
    rdc("iir ls", ADDR_IIR, 8'h06);
    push('{1'b1, 1'b0, 1'b0, 8'h42});
    repeat (3) @(posedge clk);
    rdc("lsr err", ADDR_LSR, 8'h7f);
    rdc("iir rx", ADDR_IIR, 8'h04);
    rdc("lsr clr", ADDR_LSR, 8'h61);
    rdc("data", ADDR_DATA, 8'h42);
    rdc("lsr empty", ADDR_LSR, 8'h60);
    rdc("iir none", ADDR_IIR, 8'h01);
    $display("t_line done");
  endtask : t_line
  task automatic t_fifo;
    logic [4:0] lv[4];
    lv = '{TRIG_LVL0, TRIG_LVL1, TRIG_LVL2, TRIG_LVL3};
    bus(1'b1, ADDR_IIR, 8'h01);
    rdc("iir fifo", ADDR_IIR, 8'hc1);
    bus(1'b1, ADDR_IIR, 8'h09);
    chk("dma", dma, 8'h01);
    bus(1'b1, ADDR_IER, 8'h01);
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, ADDR_IIR, {i[1:0], 6'h03});
      repeat (lv[i]) push('{1'b0, 1'b0, 1'b0, 8'h10});
      repeat (2) @(posedge clk);
      chk("at level", irq, 8'h00);
      push('{1'b0, 1'b0, 1'b0, 8'h10});
      repeat (2) @(posedge clk);
      chk("above level", irq, 8'h01);
    end
    rdc("iir level", ADDR_IIR, 8'hc4);
    bus(1'b1, ADDR_IIR, 8'hc3);
    rdc("lsr rx rst", ADDR_LSR, 8'h60);
    push('{1'b0, 1'b0, 1'b0, 8'h33});
    repeat (5) begin
      tick <= 1'b1;
      @(posedge clk);
      tick <= 1'b0;
      @(posedge clk);
    end
    rdc("iir tmo", ADDR_IIR, 8'hcc);
    rdc("data tmo", ADDR_DATA, 8'h33);
    push('{1'b0, 1'b0, 1'b0, 8'h11});
    push('{1'b0, 1'b1, 1'b0, 8'h22});
    repeat (3) @(posedge clk);
    rdc("lsr head ok", ADDR_LSR, 8'h61);
    rdc("data a", ADDR_DATA, 8'h11);
    repeat (3) @(posedge clk);
    rdc("lsr head bad", ADDR_LSR, 8'h69);
    rdc("data b", ADDR_DATA, 8'h22);
    bus(1'b1, ADDR_DATA, 8'h77);
    chk("tx held", txv, 8'h01);
    bus(1'b1, ADDR_IIR, 8'hcd);
    chk("tx rst", txv, 8'h00);
    bus(1'b1, ADDR_IIR, 8'h00);
    chk("dma off", dma, 8'h00);
    rdc("iir off", ADDR_IIR, 8'h01);
    $display("t_fifo done");
  endtask : t_fifo
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_modem();
    t_loop();
    t_tx();
    t_line();
    t_fifo();
    wrap_up();
  end
endmodule : usm_top_tb_top
